// ---- hdl/cfg_store.sv ----
// per-window timing configuration store with two registered read ports
module cfg_store (
   // clock and reset
   input  wire logic                            clk,
   input  wire logic                            nrst,
   // write port
   input  wire logic                            we,
   input  wire logic [ebus_pkg::WIN_W-1:0]      waddr,
   input  wire logic [ebus_pkg::CFG_W-1:0]      wdata,
   // read ports
   input  wire logic [ebus_pkg::WIN_W-1:0]      ra_addr,
   output logic      [ebus_pkg::CFG_W-1:0]      ra_data,
   input  wire logic [ebus_pkg::WIN_W-1:0]      rb_addr,
   output logic      [ebus_pkg::CFG_W-1:0]      rb_data
);
   logic [ebus_pkg::CFG_W-1:0] mem [ebus_pkg::NUM_WIN];

   // ==========================================================
   // storage words
   genvar gi;
   generate
      for (gi = 0; gi < ebus_pkg::NUM_WIN; gi++) begin : g_word
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               mem[gi] <= ebus_pkg::CFG_RESET;
            end else if (we && waddr == gi[ebus_pkg::WIN_W-1:0]) begin
               mem[gi] <= wdata;
            end
         end
      end
   endgenerate

   // ==========================================================
   // read data from a register, one cycle after the address
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ra_data <= ebus_pkg::CFG_RESET;
         rb_data <= ebus_pkg::CFG_RESET;
      end else begin
         ra_data <= mem[ra_addr];
         rb_data <= mem[rb_addr];
      end
   end
endmodule // cfg_store

// ---- hdl/ebus_pkg.sv ----
// constants, field layout and phase states of the external bus cycle sequencer
package ebus_pkg;
   // ==========================================================
   // register map (byte addresses on the register bus)
   localparam logic [11:0] OFS_CFG0   = 12'h000; // window n timing at OFS_CFG0 + 4n
   localparam logic [11:0] OFS_ADDR   = 12'h010;
   localparam logic [11:0] OFS_WDATA  = 12'h014;
   localparam logic [11:0] OFS_CMD    = 12'h018;
   localparam logic [11:0] OFS_STATUS = 12'h01C;
   localparam logic [11:0] OFS_CTRL   = 12'h020;
   localparam int          NUM_WIN    = 4;
   localparam int          WIN_W      = 2;

   // ==========================================================
   // window_timing_config fields
   localparam int CFG_AB     = 0;  // addr_setup_phase: 0 = 1 unit, 1 = 2 units
   localparam int CFG_ABX    = 1;  // 2 bits, extra units on window change
   localparam int CFG_C      = 3;  // 2 bits, cmd_delay_phase units
   localparam int CFG_D      = 5;  // wdata_setup_phase units
   localparam int CFG_E      = 6;  // 5 bits, access_phase units minus one
   localparam int CFG_F      = 11; // 2 bits, hold_phase units
   localparam int CFG_MUX    = 13; // shared address/data lines
   localparam int CFG_RDYEN  = 14; // ready handshake enabled
   localparam int CFG_RDYPOL = 15; // 1 = ready active high
   localparam int CFG_RDYASY = 16; // ready handled asynchronously
   localparam int CFG_UNIT   = 17; // 3 bits, phase_time_unit in clocks minus one
   localparam int CFG_W      = 20;
   localparam logic [CFG_W-1:0] CFG_RESET = 20'h00000;

   // ==========================================================
   // command, status and control fields
   localparam int CMD_RNW    = 0;
   localparam int CMD_WIN    = 1;  // 2 bits
   localparam int CMD_BLO    = 3;  // low byte enable
   localparam int CMD_BHI    = 4;  // high_byte_enable
   localparam int CMD_W      = 5;
   localparam int ST_BUSY    = 0;
   localparam int ST_PHASE   = 1;  // 3 bits
   localparam int ST_RDATA   = 16; // 16 bits
   localparam int CTRL_CLKEN = 0;
   localparam int ADDR_W     = 24;
   localparam int DATA_W     = 16;
   localparam int CNT_W      = 6;
   localparam int UNIT_W     = 3;

   // ==========================================================
   // bus cycle phases, gray coded along the cycle
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_AB   = 3'b001,
      PH_C    = 3'b011,
      PH_D    = 3'b010,
      PH_E    = 3'b110,
      PH_F    = 3'b111
   } phase_t;
endpackage

// ---- hdl/ebus_seq.sv ----
// external bus cycle sequencer with its register bus slave
// Operation
// - five phases in fixed order per cycle
// - phase lengths from per-window timing config
// - setup 1-2 units, plus 0-3 on window change
// - command 0-3, data setup 0-1, hold 0-3
// - access 1-32 units, ready may extend
// - read data taken when read strobe rises
// - reference clock pin toggles at half the system clock rate, driver enabled with CTRL_CLKEN
// - mux shares lines; demux uses separate data
// - ready active level is configurable
// - async ready adds sync stage, one wait
// - ready inactive inserts wait; active ends access phase
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
module ebus_seq (
   // clock and reset
   input  wire logic                           CLK,
   input  wire logic                           NRST,
   // register bus
   input  wire logic                           PSEL,
   input  wire logic                           PENABLE,
   input  wire logic                           PWRITE,
   input  wire logic [11:0]                    PADDR,
   input  wire logic [31:0]                    PWDATA,
   output logic      [31:0]                    PRDATA,
   output logic                                PREADY,
   output logic                                PSLVERR,
   // reference clock
   output logic                                EXTERNAL_CLOCK_OUTPUT,
   output logic                                EXTERNAL_CLOCK_OUTPUT_HS_EN,
   // external bus controls
   output logic      [ebus_pkg::NUM_WIN-1:0]   CS_N,
   output logic                                RD_N,
   output logic                                WRL_N,
   output logic                                WRH_N,
   output logic                                BHE_N,
   output logic                                ALE,
   input  wire logic                           READY,
   // address and data lines
   output logic      [ebus_pkg::ADDR_W-1:0]    A,
   input  wire logic [ebus_pkg::DATA_W-1:0]    AD_I,
   output logic      [ebus_pkg::DATA_W-1:0]    AD_O,
   output logic                                AD_OE,
   input  wire logic [ebus_pkg::DATA_W-1:0]    D_I,
   output logic      [ebus_pkg::DATA_W-1:0]    D_O,
   output logic                                D_OE
);
   // ==========================================================
   // register decode
   typedef enum logic [2:0] {
      SEL_CFG    = 3'b000,
      SEL_ADDR   = 3'b001,
      SEL_WDATA  = 3'b010,
      SEL_CMD    = 3'b011,
      SEL_STATUS = 3'b100,
      SEL_CTRL   = 3'b101,
      SEL_NONE   = 3'b111
   } reg_sel_t;

   // one aligned word per register, timing words in a block of four
   function automatic reg_sel_t decode_reg(input logic [11:0] a);
      reg_sel_t s;
      if (a[11:4] == ebus_pkg::OFS_CFG0[11:4] && a[1:0] == 2'h0) begin
         s = SEL_CFG;
      end else if (a == ebus_pkg::OFS_ADDR) begin
         s = SEL_ADDR;
      end else if (a == ebus_pkg::OFS_WDATA) begin
         s = SEL_WDATA;
      end else if (a == ebus_pkg::OFS_CMD) begin
         s = SEL_CMD;
      end else if (a == ebus_pkg::OFS_STATUS) begin
         s = SEL_STATUS;
      end else if (a == ebus_pkg::OFS_CTRL) begin
         s = SEL_CTRL;
      end else begin
         s = SEL_NONE;
      end
      return s;
   endfunction

   // ==========================================================
   // declarations
   reg_sel_t                        sel;
   logic                            acc_req, wr_done, cfg_we, start, tick, adv;
   logic                            next_pready, next_pslverr, next_external_clock_output;
   logic [31:0]                     next_prdata;
   logic                            clken, next_clken;
   logic [ebus_pkg::ADDR_W-1:0]     addr_reg, next_addr_reg, next_a;
   logic [ebus_pkg::DATA_W-1:0]     wdata_reg, next_wdata_reg, wd_lat, next_wd_lat;
   logic [ebus_pkg::DATA_W-1:0]     rdata_reg, next_rdata_reg, next_ad_o, next_d_o;
   logic [ebus_pkg::CMD_W-1:0]      cmd_reg, next_cmd_reg;
   logic [ebus_pkg::CFG_W-1:0]      cfg, cfg_rb;
   ebus_pkg::phase_t                phase, next_phase;
   logic [ebus_pkg::CNT_W-1:0]      cnt, next_cnt, ab_cnt;
   logic [ebus_pkg::UNIT_W-1:0]     ucnt, next_ucnt;
   logic [1:0]                      load, next_load;
   logic                            busy, next_busy;
   logic [ebus_pkg::WIN_W-1:0]      last_win, next_last_win, win;
   logic                            ready_s1, ready_s2, ready_s3, rdy_seen;
   logic                            rnw, blo, bhi, cyc, in_e, early, late;
   logic [ebus_pkg::NUM_WIN-1:0]    next_cs_n;
   logic                            next_rd_n, next_wrl_n, next_wrh_n, next_bhe_n;
   logic                            next_ale, next_ad_oe, next_d_oe;

   // ==========================================================
   // timing words, one per chip-select window
   cfg_store cfg_store_i (
      .clk     (CLK),
      .nrst    (NRST),
      .we      (cfg_we),
      .waddr   (PADDR[ebus_pkg::WIN_W+1:2]),
      .wdata   (PWDATA[ebus_pkg::CFG_W-1:0]),
      .ra_addr (win),
      .ra_data (cfg),
      .rb_addr (PADDR[ebus_pkg::WIN_W+1:2]),
      .rb_data (cfg_rb)
   );

   // ==========================================================
   // register bus: one wait state, so read data can come from a register
   always_comb begin
      sel            = decode_reg(PADDR);
      acc_req        = PSEL && PENABLE && !PREADY;
      wr_done        = PSEL && PENABLE && PREADY && PWRITE;
      next_pready    = acc_req;
      next_pslverr   = acc_req && sel == SEL_NONE;
      next_prdata    = PRDATA;
      if (acc_req && !PWRITE) begin
         case (sel)
            SEL_CFG:    next_prdata = {12'h000, cfg_rb};
            SEL_ADDR:   next_prdata = {8'h00, addr_reg};
            SEL_WDATA:  next_prdata = {16'h0000, wdata_reg};
            SEL_CMD:    next_prdata = {27'h0000000, cmd_reg};
            SEL_STATUS: next_prdata = {rdata_reg, 12'h000, phase, busy};
            SEL_CTRL:   next_prdata = {31'h00000000, clken};
            default:    next_prdata = 32'h00000000;
         endcase
      end
      cfg_we         = wr_done && sel == SEL_CFG;
      start          = wr_done && sel == SEL_CMD && !busy;
      next_addr_reg  = (wr_done && sel == SEL_ADDR) ? PWDATA[ebus_pkg::ADDR_W-1:0] : addr_reg;
      next_wdata_reg = (wr_done && sel == SEL_WDATA) ? PWDATA[ebus_pkg::DATA_W-1:0] : wdata_reg;
      next_cmd_reg   = start ? PWDATA[ebus_pkg::CMD_W-1:0] : cmd_reg;
      next_clken     = (wr_done && sel == SEL_CTRL) ? PWDATA[ebus_pkg::CTRL_CLKEN] : clken;
      // registered outputs only, so the pin shows a half-rate image of the clock
      next_external_clock_output    = clken ? !EXTERNAL_CLOCK_OUTPUT : 1'b0;
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         PREADY       <= 1'b0;
         PSLVERR      <= 1'b0;
         PRDATA       <= 32'h00000000;
         addr_reg     <= 24'h000000;
         wdata_reg    <= 16'h0000;
         cmd_reg      <= 5'h00;
         clken        <= 1'b0;
         EXTERNAL_CLOCK_OUTPUT_HS_EN <= 1'b0;
         EXTERNAL_CLOCK_OUTPUT       <= 1'b0;
      end else begin
         PREADY       <= next_pready;
         PSLVERR      <= next_pslverr;
         PRDATA       <= next_prdata;
         addr_reg     <= next_addr_reg;
         wdata_reg    <= next_wdata_reg;
         cmd_reg      <= next_cmd_reg;
         clken        <= next_clken;
         EXTERNAL_CLOCK_OUTPUT_HS_EN <= next_clken;
         EXTERNAL_CLOCK_OUTPUT       <= next_external_clock_output;
      end
   end

   // ==========================================================
   // ready pin: two stages always, a third one for asynchronous use
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ready_s1 <= 1'b0;
         ready_s2 <= 1'b0;
         ready_s3 <= 1'b0;
      end else begin
         ready_s1 <= READY;
         ready_s2 <= ready_s1;
         ready_s3 <= ready_s2;
      end
   end

   // ==========================================================
   // phase sequencer
   always_comb begin
      win            = cmd_reg[ebus_pkg::CMD_WIN +: ebus_pkg::WIN_W];
      rnw            = cmd_reg[ebus_pkg::CMD_RNW];
      blo            = cmd_reg[ebus_pkg::CMD_BLO];
      bhi            = cmd_reg[ebus_pkg::CMD_BHI];
      tick           = ucnt == 3'h0;
      adv            = 1'b0;
      // active level chosen per window
      rdy_seen       = (cfg[ebus_pkg::CFG_RDYASY] ? ready_s3 : ready_s2)
                       == cfg[ebus_pkg::CFG_RDYPOL];
      ab_cnt         = {5'h00, cfg[ebus_pkg::CFG_AB]}
                       + ((win != last_win) ? {4'h0, cfg[ebus_pkg::CFG_ABX +: 2]} : 6'h00);
      next_phase     = phase;
      next_cnt       = cnt;
      next_ucnt      = tick ? cfg[ebus_pkg::CFG_UNIT +: ebus_pkg::UNIT_W] : ucnt - 3'h1;
      next_load      = {load[0], start};
      next_busy      = busy || start;
      next_last_win  = last_win;
      next_rdata_reg = rdata_reg;
      case (phase)
         ebus_pkg::PH_IDLE: begin
            next_ucnt = cfg[ebus_pkg::CFG_UNIT +: ebus_pkg::UNIT_W];
            if (load[1]) begin
               next_phase = ebus_pkg::PH_AB;
               next_cnt   = ab_cnt;
            end
         end
         ebus_pkg::PH_AB, ebus_pkg::PH_C, ebus_pkg::PH_D, ebus_pkg::PH_F: begin
            if (tick && cnt == 6'h00) begin
               adv = 1'b1;
            end else if (tick) begin
               next_cnt = cnt - 6'h01;
            end
         end
         ebus_pkg::PH_E: begin
            if (tick && cnt != 6'h00) begin
               next_cnt = cnt - 6'h01;
            end else if (tick && (!cfg[ebus_pkg::CFG_RDYEN] || rdy_seen)) begin
               adv = 1'b1;
            end
         end
         default: next_phase = ebus_pkg::PH_IDLE;
      endcase
      // fixed order; zero-length phases are skipped
      if (adv) begin
         case (phase)
            ebus_pkg::PH_AB: begin
               if (cfg[ebus_pkg::CFG_C +: 2] != 2'h0) begin
                  next_phase = ebus_pkg::PH_C;
                  next_cnt   = {4'h0, cfg[ebus_pkg::CFG_C +: 2]} - 6'h01;
               end else if (cfg[ebus_pkg::CFG_D]) begin
                  next_phase = ebus_pkg::PH_D;
                  next_cnt   = 6'h00;
               end else begin
                  next_phase = ebus_pkg::PH_E;
                  next_cnt   = {1'b0, cfg[ebus_pkg::CFG_E +: 5]};
               end
            end
            ebus_pkg::PH_C: begin
               next_phase = cfg[ebus_pkg::CFG_D] ? ebus_pkg::PH_D : ebus_pkg::PH_E;
               next_cnt   = cfg[ebus_pkg::CFG_D] ? 6'h00 : {1'b0, cfg[ebus_pkg::CFG_E +: 5]};
            end
            ebus_pkg::PH_D: begin
               next_phase = ebus_pkg::PH_E;
               next_cnt   = {1'b0, cfg[ebus_pkg::CFG_E +: 5]};
            end
            ebus_pkg::PH_E: begin
               // taken at the edge that raises the read strobe
               if (rnw) begin
                  next_rdata_reg = cfg[ebus_pkg::CFG_MUX] ? AD_I : D_I;
               end
               next_last_win = win;
               if (cfg[ebus_pkg::CFG_F +: 2] != 2'h0) begin
                  next_phase = ebus_pkg::PH_F;
                  next_cnt   = {4'h0, cfg[ebus_pkg::CFG_F +: 2]} - 6'h01;
               end else begin
                  next_phase = ebus_pkg::PH_IDLE;
                  next_busy  = 1'b0;
               end
            end
            default: begin
               next_phase = ebus_pkg::PH_IDLE;
               next_busy  = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         phase     <= ebus_pkg::PH_IDLE;
         cnt       <= 6'h00;
         ucnt      <= 3'h0;
         load      <= 2'h0;
         busy      <= 1'b0;
         last_win  <= 2'h0;
         rdata_reg <= 16'h0000;
         wd_lat    <= 16'h0000;
      end else begin
         phase     <= next_phase;
         cnt       <= next_cnt;
         ucnt      <= next_ucnt;
         load      <= next_load;
         busy      <= next_busy;
         last_win  <= next_last_win;
         rdata_reg <= next_rdata_reg;
         wd_lat    <= next_wd_lat;
      end
   end

   // ==========================================================
   // pin values follow the phase being entered
   always_comb begin
      cyc         = next_phase != ebus_pkg::PH_IDLE;
      in_e        = next_phase == ebus_pkg::PH_E;
      early       = next_phase == ebus_pkg::PH_AB || next_phase == ebus_pkg::PH_C;
      late        = next_phase == ebus_pkg::PH_D || in_e || next_phase == ebus_pkg::PH_F;
      next_a      = (phase == ebus_pkg::PH_IDLE && load[1]) ? addr_reg : A;
      next_wd_lat = (phase == ebus_pkg::PH_IDLE && load[1]) ? wdata_reg : wd_lat;
      next_cs_n   = cyc ? ~(4'h1 << win) : 4'hF;
      next_rd_n   = !(in_e && rnw);
      next_wrl_n  = !(in_e && !rnw && blo);
      next_wrh_n  = !(in_e && !rnw && bhi);
      next_bhe_n  = !(cyc && bhi);
      next_ale    = next_phase == ebus_pkg::PH_AB && cfg[ebus_pkg::CFG_MUX];
      // shared lines: address first, then write data; released for reads
      next_ad_oe  = cfg[ebus_pkg::CFG_MUX] && (early || (late && !rnw));
      next_d_oe   = !cfg[ebus_pkg::CFG_MUX] && late && !rnw;
      next_ad_o   = AD_O;
      if (cfg[ebus_pkg::CFG_MUX] && early) begin
         next_ad_o = next_a[ebus_pkg::DATA_W-1:0];
      end else if (cfg[ebus_pkg::CFG_MUX] && late && !rnw) begin
         next_ad_o = next_wd_lat;
      end
      next_d_o    = next_d_oe ? next_wd_lat : D_O;
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CS_N  <= 4'hF;
         RD_N  <= 1'b1;
         WRL_N <= 1'b1;
         WRH_N <= 1'b1;
         BHE_N <= 1'b1;
         ALE   <= 1'b0;
         A     <= 24'h000000;
         AD_O  <= 16'h0000;
         AD_OE <= 1'b0;
         D_O   <= 16'h0000;
         D_OE  <= 1'b0;
      end else begin
         CS_N  <= next_cs_n;
         RD_N  <= next_rd_n;
         WRL_N <= next_wrl_n;
         WRH_N <= next_wrh_n;
         BHE_N <= next_bhe_n;
         ALE   <= next_ale;
         A     <= next_a;
         AD_O  <= next_ad_o;
         AD_OE <= next_ad_oe;
         D_O   <= next_d_o;
         D_OE  <= next_d_oe;
      end
   end
endmodule // ebus_seq

// ---- testbench/ebus_mem.sv ----
// ========
// external memory model: read pattern, write capture, ready answer
module ebus_mem (
   input wire logic        CLK, RD_N, WRL_N, AD_OE,
   input wire logic [23:0] A,
   input wire logic [15:0] AD_O, D_O,
   output logic     [15:0] AD_I, D_I,
   output logic            READY = 1'b0
);
   timeunit 1ns; timeprecision 1ns;
   logic [15:0] wlast;
   int n = 0, len = 0;
   // released lines show the inverse, so a late sample cannot pass
   assign D_I = RD_N ? ~{A[23:16], 8'hC3} : {A[23:16], 8'hC3};
   assign AD_I = D_I;
   // ready two clocks into a strobe, gone once it rises
   always @(posedge CLK) begin
      n <= (RD_N && WRL_N) ? 0 : n + 1;
      if (RD_N && WRL_N && n != 0) len <= n;
      READY <= !(RD_N && WRL_N) && n >= 1;
      if (!WRL_N) wlast <= AD_OE ? AD_O : D_O;
   end
endmodule // ebus_mem

// ---- testbench/ebus_seq_sva.sv ----
// ========
// pin-level checks of the bus cycle sequencer
module ebus_chk (
   input wire logic        CLK, NRST, RD_N, WRL_N, WRH_N, BHE_N, ALE, AD_OE, D_OE,
   input wire logic [3:0]  CS_N,
   input wire logic [23:0] A
);
   timeunit 1ns; timeprecision 1ns;
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_cs_onehot: assert property ($onehot0(~CS_N)) else $error("select");
   a_rd_wr: assert property (!RD_N |-> WRL_N && WRH_N) else $error("strobes");
   a_rd_float: assert property (!RD_N |-> !AD_OE && !D_OE) else $error("drive");
   a_rd_addr: assert property (!RD_N && $past(!RD_N) |-> $stable(A)) else $error("addr");
   a_setup_first: assert property ($fell(RD_N) || $fell(WRL_N) |-> $past(CS_N) != 4'hF)
      else $error("setup");
   a_ale_early: assert property (ALE |-> RD_N && WRL_N && CS_N != 4'hF) else $error("ale");
   a_wr_drive: assert property (!WRL_N |-> AD_OE || D_OE) else $error("wdata");
   a_wr_high: assert property (!WRH_N |-> !BHE_N) else $error("high");
   cover property (!RD_N);
   cover property (!WRL_N);
   cover property (ALE);
endmodule // ebus_chk
bind ebus_seq ebus_chk ebus_chk_i (.*);

// ---- testbench/ebus_seq_tb.sv ----
// ========
// self-checking bench of the external bus cycle sequencer
`define CHK(nm,e,s) begin n_compared++; if ((s) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %h got %h", nm, e, s); end end
module ebus_seq_tb;
   timeunit 1ns; timeprecision 1ns;
   logic CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic PREADY, PSLVERR, EXTERNAL_CLOCK_OUTPUT, EXTERNAL_CLOCK_OUTPUT_HS_EN, RD_N, WRL_N, WRH_N, BHE_N, ALE, AD_OE, D_OE;
   logic        READY;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, r;
   logic [3:0]  CS_N;
   logic [23:0] A, ad;
   logic [15:0] AD_I, AD_O, D_I, D_O, wd;
   logic [4:0]  e;
   logic        se, x;
   int n_mismatch = 0, n_compared = 0, k, j;
   always #12.5 CLK = ~CLK;
   ebus_seq ebus_seq_i (.*);
   ebus_mem ebus_mem_i (.*);
   task automatic finish_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one transfer; ready, data and error all taken at the same rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      k = 0;
      @(posedge CLK); PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CLK); PENABLE <= 1;
      do begin @(posedge CLK); k++; end while (PREADY !== 1'b1 && k < 50);
      r = PRDATA;
      se = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
      if (PREADY !== 1'b1) begin n_mismatch++; finish_test; end
   endtask
   initial begin
      void'($urandom(32'h350286ca));
      repeat (2) @(posedge CLK);
      NRST <= 1;
      apb(1, ebus_pkg::OFS_CTRL, 32'h1);
      `CHK("slverr_ok", 1'b0, se)
      @(negedge CLK) `CHK("hs_en", 1'b1, EXTERNAL_CLOCK_OUTPUT_HS_EN)
      x = EXTERNAL_CLOCK_OUTPUT;
      @(negedge CLK) `CHK("external_clock_output", ~x, EXTERNAL_CLOCK_OUTPUT)
      apb(0, 12'hFFC, 32'h0);
      `CHK("slverr", 1'b1, se)
      // mux and demux, read and write, then sync and async ready
      for (int i = 0; i < 8; i++) begin
         e = $urandom; ad = $urandom; wd = $urandom;
         apb(1, 12'(4 * (i % 4)), {15'h0, i > 6, 1'b1, i > 5, i[0], 2'($urandom), e, 6'($urandom)});
         apb(1, ebus_pkg::OFS_ADDR, 32'(ad));
         apb(1, ebus_pkg::OFS_WDATA, 32'(wd));
         apb(1, ebus_pkg::OFS_CMD, {27'h0, 2'b11, 2'(i % 4), i[1]});
         j = 0;
         do begin apb(0, ebus_pkg::OFS_STATUS, 32'h0); j++; end while (r[0] !== 1'b0 && j < 99);
         `CHK("busy", 1'b0, r[ebus_pkg::ST_BUSY])
         if (r[0] !== 1'b0) finish_test;
         if (i[1]) `CHK("rdata", {ad[23:16], 8'hC3}, r[31:16])
         else `CHK("wdata", wd, ebus_mem_i.wlast)
         if (i < 6) `CHK("len", 32'(e) + 1, ebus_mem_i.len)
      end
      finish_test;
   end
endmodule // ebus_seq_tb
